// ### hw/rstx_pkg.sv
// Purpose: Types of the scanner response transmitter
// Assumes: Used with rstx_regs.svh
// Notes:   State record is one packed struct
package rstx_pkg;

	typedef enum logic [2:0] {ST_IDLE, ST_PHA, ST_PHB, ST_LOAD,
		ST_WCTS, ST_XMIT, ST_WCONV} rstx_st_type;

	typedef enum logic [1:0] {RS_DI, RS_AI, RS_PB, RS_ND} rstx_resp_type;

	typedef struct packed {
		logic        active;
		logic        start;
		logic        bit_valid;
		logic        bit_val;
		logic        done;
		logic [18:0] word;
	} rstx_rx_type;

	typedef struct packed {
		logic overload;
		logic overflow;
		logic scan_err;
		logic pbuf_err;
	} rstx_mod_type;

	typedef struct packed {
		logic [11:0] di;
		logic [11:0] ai;
		logic [11:0] pb;
	} rstx_data_type;

	typedef struct packed {
		rstx_st_type st;
		logic [8:0]  cnt;
		logic [8:0]  xpb_cnt;
		logic [4:0]  bitcnt;
		logic [22:0] shreg;
		logic [18:0] tx_word;
		logic [17:0] cmp_word;
		logic [2:0]  l2;
		logic        load;
		logic        xmit;
		logic        err;
		logic        cmp;
		logic        cnv;
		logic        sel;
		logic        pcg;
		logic        clo;
		logic        discard;
		logic        aiq;
		logic        lineout;
		logic        online;
		logic        modem;
		logic [1:0]  saddr;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} rstx_state_type;

endpackage : rstx_pkg

// ### hw/rstx_regs.svh
// Purpose: Offsets, fields, reset values and timing counts
// Assumes: 20 MHz clock, 32-bit AXI4-Lite register bus
// Notes:   Included by the response transmitter only
`ifndef RSTX_REGS_SVH
`define RSTX_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RSTX_CTRL_OFF    8'h00
`define RSTX_STAT_OFF    8'h04
`define RSTX_RXW_OFF     8'h08
`define RSTX_TXW_OFF     8'h0C

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define RSTX_CTRL_ONLINE 0
`define RSTX_CTRL_MODEM  1
`define RSTX_CTRL_SADDR  2
`define RSTX_ONLINE_RST  1'b1
`define RSTX_MODEM_RST   1'b1
`define RSTX_SADDR_RST   2'h0

// ----------------------------------------
// Response word fields
// ----------------------------------------
`define RSTX_ND_LERR     7
`define RSTX_ND_OVLD     8
`define RSTX_ND_OVFL     9
`define RSTX_ND_SERR     10
`define RSTX_ND_PBERR    11
`define RSTX_STAT_ONES   4'hF
`define RSTX_ADDR_AIDI   3'h6
`define RSTX_ADDR_DI     3'h4
`define RSTX_ADDR_PB     3'h5

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSTX_CLK_NS      50
`define RSTX_PHASE_NS    20000
`define RSTX_PHASE_CYC   (`RSTX_PHASE_NS / `RSTX_CLK_NS)
`define RSTX_SET_NS      400
`define RSTX_SET_CYC     (`RSTX_SET_NS / `RSTX_CLK_NS)
`define RSTX_FRAME_BITS  5'h17

`endif

// ### hw/rstx_top.sv
// Purpose: Scanner response transmitter and line-error checker
// Assumes: Receive shifting done outside; inputs synchronous
// Notes:   Registers over AXI4-Lite, one aligned word each
//
// Overview of operation
// - Every reception for this scanner address is answered by a transmission, except one starting in the cycle the last reply ends
// - Address six sends digital then analog reply
// - Output-mode addresses return module status word
// - Load flag sets in phase B when idle
// - Clear word, then parallel-load selected source
// - Preset bit count; transmit waits clock, CTS
// - Start, data, address, status, parity, two stops
// - Selected flag holds until last reply sent (analog reply for address six)
// - Converting flag sets on digital reply, address six
// - Line errors give non-data reply, bit 07 set
// - Error flag allows only the non-data reply
// - Repeat bit arms compare; mismatch flags error
// - Phase drives off during compare or error, except the extra phase B with S7
// - Carrier loss while receiving sets error
// - DSR loss while receiving sets error
// - Even received parity sets error at parallelization
// - Start while selected: error, word discarded
// - Space at phase A start sets error
// - DSR loss while transmitting sets error
// - Module errors reported, ORed, arm clear flag
// - Clear flag fires extra phase B with S7
// - Receive parity starts clear, toggles on ones
// - Selected only when scanner address matches
`timescale 1ns/1ps
`include "rstx_regs.svh"

module rstx_top (
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire logic                 oscillator_tick,
	input  wire logic                 bit_tick,
	input  wire logic                 line_in,
	input  wire logic                 carrier_on_in,
	input  wire logic                 data_set_ready_in,
	input  wire logic                 clear_to_send_in,
	input  wire logic                 conversion_complete,
	input  wire rstx_pkg::rstx_rx_type   rx,
	input  wire rstx_pkg::rstx_mod_type  mod_stat,
	input  wire rstx_pkg::rstx_data_type mod_data,
	output logic                      line_out_driver,
	output logic                      phase_a_pulse,
	output logic                      phase_b_pulse,
	output logic                      select_s7_drive,
	output logic                      module_error_or,
	output logic [2:0]                module_address_buffer,
	input  wire logic [7:0]           awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [7:0]           araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready
);
	import rstx_pkg::*;

	localparam logic [8:0] PH_LAST  = 9'(`RSTX_PHASE_CYC - 1);
	localparam logic [8:0] PH_CYC   = 9'(`RSTX_PHASE_CYC);
	localparam logic [8:0] SET_LAST = 9'(`RSTX_SET_CYC);

	rstx_state_type r;
	rstx_state_type n;
	logic           err_set;
	logic           err_clr;
	logic           drv_en;
	logic           idle_not_rx_tx;
	logic           aw_go;
	logic           ar_go;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic rstx_resp_type resp_sel(input logic [2:0] a,
		input logic e, input logic ai);
		if (e)
			return RS_ND;
		else if (ai)
			return RS_AI;
		else if (a == `RSTX_ADDR_DI || a == `RSTX_ADDR_AIDI)
			return RS_DI;
		else if (a == `RSTX_ADDR_PB)
			return RS_PB;
		else
			return RS_ND;
	endfunction : resp_sel

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction : hit

	// ----------------------------------------
	// Combinational outputs
	// ----------------------------------------
	assign idle_not_rx_tx  = !rx.active && !r.xmit;
	assign drv_en          = !r.cmp && !r.err;
	assign module_error_or = mod_stat.overload | mod_stat.overflow
		| mod_stat.scan_err | mod_stat.pbuf_err;
	assign line_out_driver = r.lineout;
	assign phase_a_pulse   = (r.st == ST_PHA) && drv_en;
	assign select_s7_drive = r.xpb_cnt != 9'h000;
	assign phase_b_pulse   = ((r.st == ST_PHB) && drv_en) || select_s7_drive;
	assign module_address_buffer = r.l2;
	assign aw_go   = awvalid && wvalid && !r.bvalid;
	assign ar_go   = arvalid && !r.rvalid;
	assign awready = aw_go;
	assign wready  = aw_go;
	assign arready = ar_go;
	assign bvalid  = r.bvalid;
	assign bresp   = r.bresp;
	assign rvalid  = r.rvalid;
	assign rresp   = r.rresp;
	assign rdata   = r.rdata;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n       = r;
		err_set = 1'b0;
		err_clr = 1'b0;

		// Register bus
		if (r.bvalid && bready)
			n.bvalid = 1'b0;
		if (aw_go) begin
			n.bvalid = 1'b1;
			n.bresp  = 2'h0;
			if (hit(awaddr, `RSTX_CTRL_OFF)) begin
				if (wstrb[0]) begin
					n.online = wdata[`RSTX_CTRL_ONLINE];
					n.modem  = wdata[`RSTX_CTRL_MODEM];
					n.saddr  = wdata[`RSTX_CTRL_SADDR +: 2];
				end
			end else if (!hit(awaddr, `RSTX_STAT_OFF) && !hit(awaddr, `RSTX_RXW_OFF)
				&& !hit(awaddr, `RSTX_TXW_OFF)) begin
				n.bresp = 2'h2;
			end
		end
		if (r.rvalid && rready)
			n.rvalid = 1'b0;
		if (ar_go) begin
			n.rvalid = 1'b1;
			n.rresp  = 2'h0;
			n.rdata  = 32'h0000_0000;
			if (hit(araddr, `RSTX_CTRL_OFF))
				n.rdata[3:0] = {r.saddr, r.modem, r.online};
			else if (hit(araddr, `RSTX_STAT_OFF))
				n.rdata[13:0] = {r.l2, r.st, r.pcg, r.clo, r.xmit, r.load,
					r.sel, r.cnv, r.cmp, r.err};
			else if (hit(araddr, `RSTX_RXW_OFF))
				n.rdata[17:0] = r.cmp_word;
			else if (hit(araddr, `RSTX_TXW_OFF))
				n.rdata[18:0] = r.tx_word;
			else
				n.rresp = 2'h2;
		end

		// Line monitoring
		if (rx.active && !carrier_on_in)
			err_set = 1'b1;
		if (r.online && !data_set_ready_in && rx.active)
			err_set = 1'b1;
		if (r.online && !data_set_ready_in && r.xmit)
			err_set = 1'b1;
		if (rx.start)
			n.pcg = 1'b0;
		else if (rx.bit_valid && rx.bit_val)
			n.pcg = ~r.pcg;
		if (rx.start && r.sel) begin
			err_set   = 1'b1;
			n.discard = 1'b1;
		end
		if (r.xpb_cnt != 9'h000)
			n.xpb_cnt = r.xpb_cnt - 9'h001;

		case (r.st)
			ST_IDLE: begin
				if (rx.done && r.discard) begin
					n.discard = 1'b0;
				end else if (rx.done) begin
					if (r.pcg)
						err_set = 1'b1;
					n.l2 = rx.word[15:13];
					if (r.cmp) begin
						n.cmp = 1'b0;
						if (rx.word[17:0] != r.cmp_word)
							err_set = 1'b1;
					end else if (rx.word[18]) begin
						n.cmp      = 1'b1;
						n.cmp_word = rx.word[17:0];
					end
					if (rx.word[17:16] == r.saddr) begin
						n.sel = 1'b1;
						n.st  = ST_PHA;
						n.cnt = 9'h000;
					end
				end
			end
			ST_PHA: begin
				if (r.cnt == 9'h000 && !line_in && !r.cnv)
					err_set = 1'b1;
				if (r.cnt == PH_LAST) begin
					n.st  = ST_PHB;
					n.cnt = 9'h000;
				end else begin
					n.cnt = r.cnt + 9'h001;
				end
			end
			ST_PHB: begin
				if (oscillator_tick && idle_not_rx_tx && !r.load) begin
					n.load = 1'b1;
					n.pcg  = 1'b0;
				end
				if (r.cnt == PH_LAST) begin
					if (r.load) begin
						n.load = 1'b0;
						n.st   = ST_LOAD;
						n.cnt  = 9'h000;
					end
				end else begin
					n.cnt = r.cnt + 9'h001;
				end
			end
			ST_LOAD: begin
				n.cnt = r.cnt + 9'h001;
				if (r.cnt == 9'h000)
					n.tx_word = 19'h00000;
				if (r.cnt == 9'h001) begin
					n.tx_word[18:15] = `RSTX_STAT_ONES;
					case (resp_sel(r.l2, r.err, r.aiq))
						RS_DI: begin
							n.tx_word[14:0] = {r.l2[1:0], 1'b0, mod_data.di};
							if (r.l2 == `RSTX_ADDR_AIDI)
								n.cnv = 1'b1;
						end
						RS_AI: n.tx_word[14:0] = {r.l2[1:0], 1'b0, mod_data.ai};
						RS_PB: n.tx_word[14:0] = {r.l2[1:0], 1'b0, mod_data.pb};
						default: begin
							n.tx_word[14:13] = r.l2[1:0];
							n.tx_word[`RSTX_ND_LERR]  = r.err;
							n.tx_word[`RSTX_ND_OVLD]  = mod_stat.overload;
							n.tx_word[`RSTX_ND_OVFL]  = mod_stat.overflow;
							n.tx_word[`RSTX_ND_SERR]  = mod_stat.scan_err;
							n.tx_word[`RSTX_ND_PBERR] = mod_stat.pbuf_err;
						end
					endcase
					if (module_error_or)
						n.clo = 1'b1;
				end
				if (r.cnt == SET_LAST) begin
					n.st     = ST_WCTS;
					n.bitcnt = 5'h00;
				end
			end
			ST_WCTS: begin
				if (oscillator_tick && (!r.modem || clear_to_send_in)) begin
					n.xmit  = 1'b1;
					n.st    = ST_XMIT;
					n.shreg = {2'h3, ~^r.tx_word, r.tx_word, 1'b0};
					if (r.clo) begin
						n.clo     = 1'b0;
						n.xpb_cnt = PH_CYC;
					end
				end
			end
			ST_XMIT: begin
				if (bit_tick) begin
					if (r.bitcnt == `RSTX_FRAME_BITS) begin
						n.xmit    = 1'b0;
						n.lineout = 1'b1;
						if (r.discard) begin
							n.discard = 1'b0;
							n.st      = ST_PHB;
							n.cnt     = 9'h000;
						end else if (r.cnv && !r.aiq) begin
							n.st = ST_WCONV;
						end else begin
							n.st  = ST_IDLE;
							n.sel = 1'b0;
							n.cnv = 1'b0;
							n.aiq = 1'b0;
							err_clr = 1'b1;
						end
					end else begin
						n.lineout = r.shreg[0];
						n.shreg   = {1'b1, r.shreg[22:1]};
						n.bitcnt  = r.bitcnt + 5'h01;
					end
				end
			end
			ST_WCONV: begin
				if (conversion_complete) begin
					n.aiq = 1'b1;
					n.st  = ST_PHB;
					n.cnt = 9'h000;
				end
			end
			default: n.st = ST_IDLE;
		endcase

		n.err = err_set | (r.err & ~err_clr);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			r         <= '0;
			r.lineout <= 1'b1;
			r.online  <= `RSTX_ONLINE_RST;
			r.modem   <= `RSTX_MODEM_RST;
			r.saddr   <= `RSTX_SADDR_RST;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	AST_LOAD_IDLE: assert property ($rose(r.load) |-> $past(r.st) == ST_PHB
		&& !$past(rx.active) && !$past(r.xmit) && $past(oscillator_tick))
		else $error("load flag set outside idle phase B");
	AST_XMIT_CTS: assert property ($rose(r.xmit) |-> $past(oscillator_tick)
		&& (!$past(r.modem) || $past(clear_to_send_in)))
		else $error("transmit began without clock or CTS");
	AST_START_BIT: assert property (r.xmit && bit_tick && r.bitcnt == 5'h00
		|=> !line_out_driver)
		else $error("first bit out is not a start bit");
	AST_ODD_PARITY: assert property ($rose(r.xmit) |-> (^r.shreg[20:1])
		&& r.shreg[22:21] == 2'h3 && !r.shreg[0])
		else $error("frame parity or stop bits wrong");
	AST_IDLE_MARK: assert property (!r.xmit |-> line_out_driver)
		else $error("line not at mark while idle");
	AST_ERR_ND: assert property (r.st == ST_LOAD && r.cnt == 9'h001 && r.err
		|=> r.tx_word[`RSTX_ND_LERR] && r.tx_word[18:15] == 4'hF)
		else $error("error response missing bit 07");
	AST_PH_GATE: assert property ((r.cmp || r.err) && !select_s7_drive
		|-> !phase_a_pulse && !phase_b_pulse)
		else $error("phase drive during compare or error");
	AST_CARRIER: assert property (rx.active && !carrier_on_in |=> r.err)
		else $error("carrier loss did not set error");
	AST_CONV: assert property (r.st == ST_LOAD && r.cnt == 9'h001 && !r.err
		&& !r.aiq && r.l2 == 3'h6 |=> r.cnv)
		else $error("converting flag not set for address six");
	AST_DSR_TX: assert property (r.online && r.xmit && !data_set_ready_in
		|=> r.err)
		else $error("DSR loss in transmit did not set error");
	AST_EXTRA_PHB: assert property ($rose(select_s7_drive)
		|-> phase_b_pulse [*8])
		else $error("extra phase B pulse too short");

endmodule : rstx_top

// ### verification/rstx_modem.sv
// Purpose: Modem model at the far end of the response line
// Assumes: Frame is start, 19 word bits, parity, two stops
// Notes:   Carrier and CTS follow bench commands
`timescale 1ns/1ps

module rstx_modem (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        bit_tick,
	input  wire logic        line_out_driver,
	input  wire logic        carrier_drop,
	input  wire logic        cts_slow,
	input  wire logic        dsr_drop,
	output logic             carrier_on_in,
	output logic             data_set_ready_in,
	output logic             clear_to_send_in,
	output logic             frame_valid,
	output logic [21:0]      frame_bits
);
	logic [4:0] idx_r;
	logic [6:0] cts_cnt_r;

	assign carrier_on_in     = !carrier_drop;
	// DSR follows the bench command
	assign data_set_ready_in = !dsr_drop;
	// Slow partner grants CTS half the time only
	assign clear_to_send_in  = !cts_slow || cts_cnt_r[6];

	// Line sampled at each bit time, before the driver moves on
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			idx_r <= 5'h00;
			cts_cnt_r <= 7'h00;
			frame_valid <= 1'h0;
			frame_bits <= 22'h000000;
		end else begin
			frame_valid <= 1'h0;
			cts_cnt_r <= cts_cnt_r + 7'h01;
			if (bit_tick && idx_r == 5'h00) begin
				if (!line_out_driver)
					idx_r <= 5'h01;
			end else if (bit_tick) begin
				frame_bits <= {line_out_driver, frame_bits[21:1]};
				idx_r <= (idx_r == 5'h16) ? 5'h00 : idx_r + 5'h01;
				frame_valid <= (idx_r == 5'h16);
			end
		end
	end
endmodule : rstx_modem

// ### verification/test_remote_scanner_response_tx.sv
// Purpose: Self-checking bench of the response transmitter
// Assumes: Modem model on the line, modules modelled here
// Notes:   Expected words built in the bench from the field layout
`timescale 1ns/1ps

module test_remote_scanner_response_tx;
	import rstx_pkg::*;
	logic clock = 1'h0, reset = 1'h1, osc = 1'h0, btk = 1'h0, line_in = 1'h1, conv = 1'h0;
	logic car_drop = 1'h0, cts_slow = 1'h0, car, dsr, cts, fv, lo, pa, pb, s7, meo, s7_seen;
	logic dsr_drop = 1'h0, pa_seen;
	logic [21:0] fb;
	logic [2:0] mab;
	rstx_rx_type rx = '0;
	rstx_mod_type ms = '0;
	rstx_data_type md = '0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'h0, tc = 4'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [15:0] rnd = 16'h005E;
	logic [18:0] last;
	logic [21:0] frames[$];
	int error_cnt = 0, checks_done = 0;

	always #25 clock = ~clock;

	// Bit time every 8 cycles, oscillator every 4
	always @(posedge clock) begin
		tc <= tc + 4'h1;
		btk <= (tc[2:0] == 3'h7);
		osc <= (tc[1:0] == 2'h3);
	end

	// Addressed module clears its error on extra phase B with S7
	always @(posedge clock) begin
		if (fv)
			frames.push_back(fb);
		if (pb && s7) begin
			ms <= '0;
			s7_seen <= 1'h1;
		end
		if (pa)
			pa_seen <= 1'h1;
	end

	rstx_top u_rstx_top (.clock(clock), .reset(reset), .oscillator_tick(osc), .bit_tick(btk),
		.line_in(line_in), .carrier_on_in(car), .data_set_ready_in(dsr),
		.clear_to_send_in(cts), .conversion_complete(conv), .rx(rx), .mod_stat(ms),
		.mod_data(md), .line_out_driver(lo), .phase_a_pulse(pa), .phase_b_pulse(pb),
		.select_s7_drive(s7), .module_error_or(meo), .module_address_buffer(mab),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));

	rstx_modem u_rstx_modem (.clock(clock), .reset(reset), .bit_tick(btk),
		.line_out_driver(lo), .carrier_drop(car_drop), .cts_slow(cts_slow), .dsr_drop(dsr_drop),
		.carrier_on_in(car), .data_set_ready_in(dsr), .clear_to_send_in(cts),
		.frame_valid(fv), .frame_bits(fb));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [18:0] resp(input logic [2:0] a, input logic [11:0] v,
		input logic nd, input logic e);
		if (nd || e)
			return {4'hF, a[1:0], 1'h0, ms.pbuf_err, ms.scan_err, ms.overflow, ms.overload,
				e, 7'h00};
		return {4'hF, a[1:0], 1'h0, v};
	endfunction : resp

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do @(negedge clock); while (!(awready && wready));
		@(posedge clock);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		do @(negedge clock); while (!bvalid);
		rs = bresp;
		@(posedge clock);
		bready <= 1'h0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(negedge clock); while (!arready);
		@(posedge clock);
		arvalid <= 1'h0;
		do @(negedge clock); while (!rvalid);
		v = rdata;
		rs = rresp;
		@(posedge clock);
		rready <= 1'h0;
	endtask : axi_rd

	// Kind 1 bad parity, 2 carrier loss, 3 line at space, 4/5 repeat match/miss,
	// 6 DSR loss receiving, 7 DSR loss transmitting, 8 word during reply
	task automatic send_word(input logic [18:0] w, input int k);
		logic b;
		rx.active <= 1'h1;
		rx.start <= 1'h1;
		@(posedge clock);
		rx.start <= 1'h0;
		for (int i = 0; i < 21; i++) begin
			b = (i < 19) ? w[i] : (i == 19) ? (~^w ^ (k == 1)) : 1'h1;
			rx.bit_valid <= 1'h1;
			rx.bit_val <= b;
			if (k == 2 && i == 10)
				car_drop <= 1'h1;
			if (k == 6 && i == 10)
				dsr_drop <= 1'h1;
			@(posedge clock);
			rx.bit_valid <= 1'h0;
			@(posedge clock);
		end
		rx.word <= w;
		rx.done <= 1'h1;
		rx.active <= 1'h0;
		if (k == 3)
			line_in <= 1'h0;
		@(posedge clock);
		rx.done <= 1'h0;
		repeat (4) @(posedge clock);
		line_in <= 1'h1;
		car_drop <= 1'h0;
		dsr_drop <= 1'h0;
	endtask : send_word

	task automatic get_frame(input logic [18:0] e);
		int n = 0;
		while (frames.size() == 0 && n < 5000) begin
			@(posedge clock);
			n++;
		end
		check(32'(frames.size() != 0), 32'h1);
		if (frames.size() != 0)
			check(32'(frames.pop_front()), {10'h0, 2'h3, ~^e, e});
		last = e;
	endtask : get_frame

	task automatic run_word(input logic [2:0] a, input int k);
		logic [3:0]  m0;
		logic [18:0] w;
		rnd = lfsr(rnd);
		m0 = rnd[3:0];
		w = {k == 4 || k == 5, 2'h0, a, rnd[12:0]};
		md <= {rnd[11:0], rnd[15:4], ~rnd[11:0]};
		ms <= m0;
		cts_slow <= (k == 3);
		s7_seen <= 1'h0;
		@(posedge clock);
		check(32'(meo), 32'(|m0));
		if (k == 4 || k == 5) begin
			send_word(w, 0);
			get_frame(resp(a, md.di, 1'h0, 1'h0));
			w[0] = w[0] ^ (k == 5);
		end
		pa_seen <= 1'h0;
		send_word(w, k);
		check(32'(mab), 32'(a));
		if (k > 6) begin
			while (lo)
				@(posedge clock);
			if (k == 7) begin
				dsr_drop <= 1'h1;
				@(posedge clock);
				dsr_drop <= 1'h0;
				axi_rd(8'h04, d, r);
				check(32'(d[0]), 32'h1);
			end else begin
				send_word(w, 0);
				get_frame(resp(a, md.di, 1'h0, 1'h0));
			end
		end
		get_frame(resp(a, (a == 3'h5) ? md.pb : md.di, !(a inside {3'h4, 3'h5, 3'h6}),
			!(k inside {0, 4, 7})));
		check(32'(pa_seen), 32'(k inside {0, 3, 4, 7, 8}));
		if (a == 3'h6 && k == 0) begin
			axi_rd(8'h04, d, r);
			check(32'(d[3:2]), 32'h3);
			conv <= 1'h1;
			get_frame(resp(a, md.ai, 1'h0, 1'h0));
			conv <= 1'h0;
		end
		repeat (500) @(posedge clock);
		check(32'(s7_seen), 32'(|m0));
		$display("test word %0d kind %0d done", a, k);
	endtask : run_word

	initial begin
		repeat (80000) @(posedge clock);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'h0;
		@(posedge clock);
		check(32'(lo), 32'h1);
		axi_rd(8'h00, d, r);
		check(d, 32'h3);
		axi_rd(8'h04, d, r);
		check(32'(d[5:0]), 32'h0);
		axi_rd(8'h10, d, r);
		check(32'(r), 32'h2);
		axi_wr(8'h04, 32'hFFFFFFFF, r);
		check(32'(r), 32'h0);
		axi_wr(8'h00, 32'h3, r);
		$display("test registers done");
		for (int a = 0; a < 8; a++)
			run_word(3'(a), 0);
		for (int k = 1; k < 9; k++)
			run_word(3'h4, k);
		send_word({1'h0, 2'h2, 3'h4, 13'h0}, 0);
		repeat (3000) @(posedge clock);
		check(32'(frames.size()), 32'h0);
		axi_rd(8'h0C, d, r);
		check(d, {13'h0, last});
		$display("test foreign address done");
		tally_and_finish();
	end
endmodule : test_remote_scanner_response_tx
